//--- sim/rtc_i2c_slave_interface_test.sv
/* Self-checking bench of the two-wire slave port: the master model drives
   the pins, a byte array stands in for the chip's registers.
   Assumes the design sources and the master model are compiled first. */
`timescale 1ns/1ps

module rtc_i2c_slave_interface_test;
   // =====================================================================
   // signals
   localparam logic [6:0] DEV = 7'h2A; // arbitrary address
   logic        core_clk;
   logic        nrst;
   logic        scl;
   logic        sdaLow;
   logic        resValid;
   logic [7:0]  resVal;
   logic        sdaOut_ff;
   logic        sdaOe_ff;
   logic [5:0]  regPtr_ff;
   logic [7:0]  rdData;
   logic [7:0]  wrData_ff;
   logic        wrStrobe_ff;
   logic        snapStrobe_ff;
   logic        divReset_ff;
   wire logic   sdaLine;
   logic [7:0]  mem [64];
   logic [7:0]  shadow [64];
   logic [7:0]  expQ [$];
   logic [13:0] wrQ [$];
   logic [13:0] wrNote;
   logic [5:0]  ptrExp;
   logic [5:0]  p;
   int          n;
   int          miscompares;
   int          checks;

   // open drain: the slave pulls only when it enables a low output value
   assign sdaLine = !(sdaLow || (sdaOe_ff && (sdaOut_ff === 1'b0)));
   assign rdData = mem[regPtr_ff];

   rtcif_i2c_slave #(.DEV_ADDR(DEV)) rtcif_i2c_slave_inst (
      .core_clk(core_clk), .nrst(nrst), .sclIn(scl), .sdaIn(sdaLine),
      .sdaOut_ff(sdaOut_ff), .sdaOe_ff(sdaOe_ff), .regPtr_ff(regPtr_ff),
      .rdData(rdData), .wrData_ff(wrData_ff), .wrStrobe_ff(wrStrobe_ff),
      .snapStrobe_ff(snapStrobe_ff), .divReset_ff(divReset_ff)
   );

   rtcif_master_model rtcif_master_model_inst (
      .core_clk(core_clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow),
      .resValid(resValid), .resVal(resVal)
   );

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // =====================================================================
   // comparison and monitors
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   always @(posedge core_clk) begin
      if (wrStrobe_ff === 1'b1) begin
         mem[regPtr_ff - 6'h01] <= wrData_ff;
         wrNote = wrQ.size() > 0 ? wrQ.pop_front() : 14'h3FFF;
         check({2'h0, 6'(regPtr_ff - 6'h01)}, {2'h0, wrNote[13:8]});
         check(wrData_ff, wrNote[7:0]);
         check({7'h00, divReset_ff}, {7'h00, wrNote[13:8] == 6'h00});
      end
      if (resValid === 1'b1) begin
         check(resVal, expQ.size() > 0 ? expQ.pop_front() : 8'hEE);
      end
   end

   // =====================================================================
   // transfers
   task automatic wrXfer(input logic [6:0] adr, input logic [5:0] ptr, input int cnt,
                         input logic rep);
      logic       ok;
      logic [7:0] d;
      ok = (adr == DEV);
      rtcif_master_model_inst.startCond();
      expQ.push_back({7'h00, ok});
      rtcif_master_model_inst.sendByte({adr, 1'b0});
      if (ok)
         ptrExp = ptr;
      expQ.push_back({7'h00, ok});
      rtcif_master_model_inst.sendByte({2'b10, ptr});
      for (int i = 0; i < cnt; i++) begin
         d = 8'($urandom);
         expQ.push_back({7'h00, ok});
         if (ok) begin
            wrQ.push_back({ptrExp, d});
            shadow[ptrExp] = d;
            ptrExp++;
         end
         rtcif_master_model_inst.sendByte(d);
      end
      if (!rep)
         rtcif_master_model_inst.stopCond();
   endtask

   task automatic rdXfer(input int cnt);
      rtcif_master_model_inst.startCond();
      expQ.push_back(8'h01);
      rtcif_master_model_inst.sendByte({DEV, 1'b1});
      for (int i = 0; i < cnt; i++) begin
         expQ.push_back(shadow[ptrExp]);
         ptrExp++;
         rtcif_master_model_inst.recvByte(i != cnt - 1);
      end
      rtcif_master_model_inst.stopCond();
   endtask

   task automatic conclude();
      if (expQ.size() + wrQ.size() != 0)
         miscompares++;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // =====================================================================
   // main sequence
   initial begin
      void'($urandom(26));
      miscompares = 0;
      checks = 0;
      ptrExp = 6'h00;
      nrst = 1'b0;
      for (int i = 0; i < 64; i++) begin
         mem[i] = 8'($urandom);
         shadow[i] = mem[i];
      end
      repeat (2) @(negedge core_clk);
      nrst = 1'b1;
      repeat (6) @(negedge core_clk);
      wrXfer(DEV, 6'h3E, 3, 1'b0);
      rdXfer(3);
      wrXfer(DEV, 6'h3F, 0, 1'b0);
      rdXfer(2);
      wrXfer(DEV ^ 7'h01, 6'h05, 2, 1'b0);
      rdXfer(1);
      for (int k = 0; k < 4; k++) begin
         rtcif_master_model_inst.lowExtra = $urandom_range(0, 40);
         n = $urandom_range(1, 4);
         p = 6'($urandom);
         wrXfer(DEV, p, n, 1'b0);
         wrXfer(DEV, p, 0, 1'b1);
         rdXfer(n + 1);
      end
      repeat (20) @(negedge core_clk);
      conclude();
   end

   // hang guard: the longest legal run needs about 66000 cycles
   initial begin
      repeat (90000) @(posedge core_clk);
      miscompares++;
      conclude();
   end
endmodule

//--- sim/rtcif_master_model.sv
/* Two-wire bus master model: START, STOP, byte write and byte read.
   Assumes a pulled-up data wire fed back on sdaLine; bit spacing is
   shortened to keep the run short. */
`timescale 1ns/1ps

module rtcif_master_model #(
   // quarter bit in core cycles, far above the slave's sync latency
   parameter int QTR = 16
) (
   // clock
   input  wire logic       core_clk,
   // wire
   input  wire logic       sdaLine,
   output logic            scl,
   output logic            sdaLow,
   // observed results
   output logic            resValid,
   output logic      [7:0] resVal
);
   int lowExtra = 0;

   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
      resValid = 1'b0;
      resVal = 8'h00;
   end

   task automatic waitQ(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // only master makes clock; data set in low phase, sampled mid high
   task automatic bitCycle(input logic b, output logic r);
      sdaLow = !b;
      waitQ(QTR + lowExtra);
      scl = 1'b1;
      waitQ(QTR);
      r = sdaLine;
      waitQ(QTR);
      scl = 1'b0;
      waitQ(QTR);
   endtask

   task automatic report(input logic [7:0] v);
      resVal = v;
      resValid = 1'b1;
      waitQ(1);
      resValid = 1'b0;
   endtask

   task automatic startCond();
      sdaLow = 1'b0;
      waitQ(QTR);
      scl = 1'b1;
      waitQ(QTR);
      sdaLow = 1'b1;
      waitQ(QTR);
      scl = 1'b0;
      waitQ(QTR);
   endtask

   task automatic stopCond();
      sdaLow = 1'b1;
      waitQ(QTR);
      scl = 1'b1;
      waitQ(QTR);
      sdaLow = 1'b0;
      waitQ(2 * QTR);
   endtask

   task automatic sendByte(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitCycle(b[i], r);
      end
      bitCycle(1'b1, r);
      report({7'h00, !r});
   endtask

   task automatic recvByte(input logic ackIt);
      logic [7:0] v;
      logic       r;
      for (int i = 7; i >= 0; i--) begin
         bitCycle(1'b1, r);
         v[i] = r;
      end
      bitCycle(!ackIt, r);
      report(v);
   endtask
endmodule

//--- sim/rtcif_slave_props.sv
/* Concurrent checks on the pins and register side of the two-wire slave port.
   Assumes it is bound to rtcif_i2c_slave; single clock domain. */
`timescale 1ns/1ps

module rtcif_slave_props #(
   parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary value
   parameter int         PTR_W    = 6
) (
   // clock and reset
   input wire logic             core_clk,
   input wire logic             nrst,
   // pins
   input wire logic             sclIn,
   input wire logic             sdaIn,
   input wire logic             sdaOut_ff,
   input wire logic             sdaOe_ff,
   // register side
   input wire logic [PTR_W-1:0] regPtr_ff,
   input wire logic [7:0]       rdData,
   input wire logic [7:0]       wrData_ff,
   input wire logic             wrStrobe_ff,
   input wire logic             snapStrobe_ff,
   input wire logic             divReset_ff
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   // =====================================================================
   // conditions
   AST_SNAP_ON_START: assert property (
      sclIn && $fell(sdaIn) |-> ##[4:7] snapStrobe_ff)
      else $error("no snapshot pulse after start");
   AST_SNAP_PULSE: assert property (snapStrobe_ff |=> !snapStrobe_ff)
      else $error("snapshot pulse too long");
   AST_STOP_RELEASE: assert property (sclIn && $rose(sdaIn) |=> !sdaOe_ff [*8])
      else $error("data line pulled after stop");

   // =====================================================================
   // data line timing
   AST_OE_RISE_LOW: assert property ($rose(sdaOe_ff) |-> !sclIn && !$past(sclIn, 3))
      else $error("data pulled low outside clock low phase");
   AST_OE_FALL_LOW: assert property ($fell(sdaOe_ff) |-> !sclIn)
      else $error("data released during clock high");
   AST_OE_STANDS: assert property ($rose(sdaOe_ff) |=> sdaOe_ff [*8])
      else $error("data low too short");

   // =====================================================================
   // writes and pointer
   AST_STROBE_ACK: assert property (wrStrobe_ff |-> $rose(sdaOe_ff))
      else $error("write not at acknowledge");
   AST_WR_PULSE: assert property (wrStrobe_ff |=> !wrStrobe_ff)
      else $error("write pulse too long");
   AST_PTR_STEP: assert property (
      wrStrobe_ff |-> regPtr_ff == PTR_W'($past(regPtr_ff) + 1))
      else $error("pointer not advanced by one on write");
   AST_DIV_SECONDS: assert property (
      wrStrobe_ff |-> divReset_ff == (regPtr_ff == PTR_W'(1)))
      else $error("divider reset does not match seconds write");
   AST_DIV_ONLY_WRITE: assert property (divReset_ff |-> wrStrobe_ff)
      else $error("divider reset without write");
   AST_PTR_STILL: assert property ($changed(regPtr_ff) |-> !sclIn)
      else $error("pointer moved during clock high");
endmodule

bind rtcif_i2c_slave rtcif_slave_props #(.DEV_ADDR(DEV_ADDR), .PTR_W(PTR_W))
   rtcif_slave_props_inst (
   .core_clk(core_clk), .nrst(nrst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut_ff(sdaOut_ff),
   .sdaOe_ff(sdaOe_ff), .regPtr_ff(regPtr_ff), .rdData(rdData), .wrData_ff(wrData_ff),
   .wrStrobe_ff(wrStrobe_ff), .snapStrobe_ff(snapStrobe_ff), .divReset_ff(divReset_ff)
);

//--- src/rtcif_bus_cond.sv
/*
 * Clock edges and START/STOP conditions of the two-wire link.
 * Assumes filtered clock and data levels on core_clk.
 */
`timescale 1ns/1ps
`include "rtcif_consts.svh"

module rtcif_bus_cond (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic nrst,
   // filtered line levels
   input  wire logic scl,
   input  wire logic sda,
   // one-cycle events
   output logic      sclRise_ff,
   output logic      sclFall_ff,
   output logic      startSeen_ff,
   output logic      stopSeen_ff
);

   logic sclPrev_ff;
   logic sdaPrev_ff;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sclPrev_ff <= `RTCIF_LINE_IDLE;
         sdaPrev_ff <= `RTCIF_LINE_IDLE;
      end else begin
         sclPrev_ff <= scl;
         sdaPrev_ff <= sda;
      end
   end

   // =====================================================================
   // edges and conditions
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sclRise_ff   <= 1'b0;
         sclFall_ff   <= 1'b0;
         startSeen_ff <= 1'b0;
         stopSeen_ff  <= 1'b0;
      end else begin
         sclRise_ff   <= scl & ~sclPrev_ff;
         sclFall_ff   <= ~scl & sclPrev_ff;
         startSeen_ff <= scl & sclPrev_ff & sdaPrev_ff & ~sda;
         stopSeen_ff  <= scl & sclPrev_ff & ~sdaPrev_ff & sda;
      end
   end

endmodule

//--- src/rtcif_consts.svh
/*
 * Constants of the clock/calendar two-wire slave port: bit counts,
 * pointer layout and reset levels.
 * Assumes it is included by its bare name before any use.
 */
`ifndef RTCIF_CONSTS_SVH
`define RTCIF_CONSTS_SVH

// =====================================================================
// link framing
`define RTCIF_ADDR_BITS   7
`define RTCIF_BYTE_BITS   4'h8
`define RTCIF_CNT_W       4
`define RTCIF_DIR_READ    1'b1
`define RTCIF_SYNC_STAGES 3
`define RTCIF_LINE_IDLE   1'b1

// =====================================================================
// register pointer
`define RTCIF_PTR_W       6
`define RTCIF_PTR_RESET   6'h00
`define RTCIF_PTR_TOP     6'h3F
`define RTCIF_PTR_FIRST   6'h00
`define RTCIF_PTR_SECONDS 6'h00

// =====================================================================
// timing: standard-mode ceiling and core clock
`define RTCIF_SCL_MAX_KHZ 100
`define RTCIF_CORE_MHZ    250
`define RTCIF_SCL_MIN_CYC ((`RTCIF_CORE_MHZ * 1000) / `RTCIF_SCL_MAX_KHZ)

`endif

//--- src/rtcif_i2c_slave.sv
/*
 * Two-wire slave port of the clock/calendar: address match, acknowledge,
 * register pointer with auto-increment, read and write sequencing.
 * Assumes the rest of the chip returns rdData for regPtr_ff in the same
 * cycle, takes wrData_ff at wrStrobe_ff, copies time into its read
 * buffers at snapStrobe_ff and resets its divider at divReset_ff.
 */
// How it works
// - slave only; master makes clock, START, STOP
// - idle is both lines high
// - data falling while clock high is START
// - data rising while clock high is STOP
// - data changes only while clock low
// - bytes plus ninth acknowledge bit, unlimited count
// - acknowledger holds data low through high phase
// - every byte travels MSB first
// - repeated START handled as fresh START
// - first byte is 7-bit address plus direction
// - matching address is acknowledged
// - first written byte loads the pointer
// - later written bytes stored, acknowledged, pointer advanced
// - reads start at the retained pointer
// - pointer advances after each transmitted byte
// - on no acknowledge, release data high
// - pointer wraps from top back to zero
// - each START refreshes the time read buffers
// - written byte takes effect at its acknowledge
// - seconds write resets the divider chain
`timescale 1ns/1ps
`include "rtcif_consts.svh"

module rtcif_i2c_slave #(
   // arbitrary value, set per product
   parameter logic [`RTCIF_ADDR_BITS-1:0] DEV_ADDR = 7'h2A,
   parameter int                          PTR_W    = `RTCIF_PTR_W
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             nrst,
   // two-wire pins
   input  wire logic             sclIn,
   input  wire logic             sdaIn,
   output logic                  sdaOut_ff,
   output logic                  sdaOe_ff,
   // register side of the chip
   output logic      [PTR_W-1:0] regPtr_ff,
   input  wire logic [7:0]       rdData,
   output logic      [7:0]       wrData_ff,
   output logic                  wrStrobe_ff,
   // timekeeping side effects
   output logic                  snapStrobe_ff,
   output logic                  divReset_ff
);

   // =====================================================================
   // parameter checks
   if (PTR_W != `RTCIF_PTR_W) begin : g_chk_ptr
      $error("rtcif_i2c_slave: pointer must match the 64-byte space");
   end
   if (`RTCIF_SCL_MIN_CYC < 16) begin : g_chk_rate
      $error("rtcif_i2c_slave: core clock too slow to oversample the link");
   end

   // =====================================================================
   // pointer step with wrap at the top of RAM
   function automatic logic [PTR_W-1:0] ptrStep(input logic [PTR_W-1:0] p);
      if (p == `RTCIF_PTR_TOP) begin
         ptrStep = `RTCIF_PTR_FIRST;
      end else begin
         ptrStep = p + 1'b1;
      end
   endfunction

   // =====================================================================
   // synchronised lines and bus events
   logic [1:0] lineLvl;
   logic       sclLvl;
   logic       sdaLvl;
   logic       sclRise;
   logic       sclFall;
   logic       startSeen;
   logic       stopSeen;

   rtcif_pin_sync #(
      .WIDTH (2)
   ) u_sync (
      .core_clk (core_clk),
      .nrst     (nrst),
      .pinIn    ({sclIn, sdaIn}),
      .level_ff (lineLvl)
   );

   assign sclLvl = lineLvl[1];
   assign sdaLvl = lineLvl[0];

   rtcif_bus_cond u_cond (
      .core_clk     (core_clk),
      .nrst         (nrst),
      .scl          (sclLvl),
      .sda          (sdaLvl),
      .sclRise_ff   (sclRise),
      .sclFall_ff   (sclFall),
      .startSeen_ff (startSeen),
      .stopSeen_ff  (stopSeen)
   );

   // =====================================================================
   // transfer state
   rtcif_pkg::rtcif_state_e     state_ff;
   logic [`RTCIF_CNT_W-1:0]     bitCnt_ff;
   logic [7:0]                  rxShift_ff;
   logic [7:0]                  txShift_ff;
   logic                        readDir_ff;
   logic                        ptrPending_ff;
   logic                        byteDone;
   logic                        addrMatch;

   assign byteDone  = (bitCnt_ff == `RTCIF_BYTE_BITS);
   assign addrMatch = (rxShift_ff[7:1] == DEV_ADDR);

   // =====================================================================
   // state machine; conditions are taken on any state
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_ff <= rtcif_pkg::RTCIF_IDLE;
      end else if (startSeen) begin
         state_ff <= rtcif_pkg::RTCIF_ADDR;
      end else if (stopSeen) begin
         state_ff <= rtcif_pkg::RTCIF_IDLE;
      end else begin
         unique case (state_ff)
            rtcif_pkg::RTCIF_IDLE, rtcif_pkg::RTCIF_IGNORE: begin
               state_ff <= state_ff;
            end
            rtcif_pkg::RTCIF_ADDR: begin
               if (sclFall && byteDone) begin
                  state_ff <= addrMatch ? rtcif_pkg::RTCIF_AACK
                                        : rtcif_pkg::RTCIF_IGNORE;
               end
            end
            rtcif_pkg::RTCIF_AACK: begin
               if (sclFall) begin
                  state_ff <= readDir_ff ? rtcif_pkg::RTCIF_TXBYTE
                                         : rtcif_pkg::RTCIF_RXBYTE;
               end
            end
            rtcif_pkg::RTCIF_RXBYTE: begin
               if (sclFall && byteDone) begin
                  state_ff <= rtcif_pkg::RTCIF_RXACK;
               end
            end
            rtcif_pkg::RTCIF_RXACK: begin
               if (sclFall) begin
                  state_ff <= rtcif_pkg::RTCIF_RXBYTE;
               end
            end
            rtcif_pkg::RTCIF_TXBYTE: begin
               if (sclFall && byteDone) begin
                  state_ff <= rtcif_pkg::RTCIF_TXACK;
               end
            end
            rtcif_pkg::RTCIF_TXACK: begin
               if (sclRise && sdaLvl) begin
                  state_ff <= rtcif_pkg::RTCIF_IGNORE;
               end else if (sclFall) begin
                  state_ff <= rtcif_pkg::RTCIF_TXBYTE;
               end
            end
            default: begin
               state_ff <= rtcif_pkg::RTCIF_IDLE;
            end
         endcase
      end
   end

   // =====================================================================
   // bit counter: one bit per clock pulse
   always_ff @(posedge core_clk) begin
      if (!nrst || startSeen) begin
         bitCnt_ff <= '0;
      end else if (sclFall && byteDone) begin
         bitCnt_ff <= '0;
      end else if (sclRise && (state_ff == rtcif_pkg::RTCIF_ADDR ||
                               state_ff == rtcif_pkg::RTCIF_RXBYTE ||
                               state_ff == rtcif_pkg::RTCIF_TXBYTE)) begin
         bitCnt_ff <= bitCnt_ff + 1'b1;
      end
   end

   // =====================================================================
   // receive shifter, sampled on clock high
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rxShift_ff <= '0;
      end else if (sclRise && (state_ff == rtcif_pkg::RTCIF_ADDR ||
                               state_ff == rtcif_pkg::RTCIF_RXBYTE)) begin
         rxShift_ff <= {rxShift_ff[6:0], sdaLvl};
      end
   end

   // =====================================================================
   // direction taken from each address byte; pointer-load flag fresh on every START
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         readDir_ff    <= 1'b0;
         ptrPending_ff <= 1'b0;
      end else if (startSeen) begin
         ptrPending_ff <= 1'b1;
      end else if (state_ff == rtcif_pkg::RTCIF_ADDR && sclFall && byteDone) begin
         readDir_ff <= (rxShift_ff[0] == `RTCIF_DIR_READ);
      end else if (state_ff == rtcif_pkg::RTCIF_RXBYTE && sclFall && byteDone) begin
         ptrPending_ff <= 1'b0;
      end
   end

   // =====================================================================
   // register pointer, kept across transfers
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         regPtr_ff <= `RTCIF_PTR_RESET;
      end else if (sclFall && byteDone) begin
         if (state_ff == rtcif_pkg::RTCIF_RXBYTE) begin
            if (ptrPending_ff) begin
               regPtr_ff <= rxShift_ff[PTR_W-1:0];
            end else begin
               regPtr_ff <= ptrStep(regPtr_ff);
            end
         end else if (state_ff == rtcif_pkg::RTCIF_TXBYTE) begin
            regPtr_ff <= ptrStep(regPtr_ff);
         end
      end
   end

   // =====================================================================
   // write strobe as the acknowledge goes out
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wrData_ff   <= '0;
         wrStrobe_ff <= 1'b0;
         divReset_ff <= 1'b0;
      end else begin
         wrStrobe_ff <= 1'b0;
         divReset_ff <= 1'b0;
         if (state_ff == rtcif_pkg::RTCIF_RXBYTE && sclFall && byteDone &&
             !ptrPending_ff) begin
            wrData_ff   <= rxShift_ff;
            wrStrobe_ff <= 1'b1;
            divReset_ff <= (regPtr_ff == `RTCIF_PTR_SECONDS);
         end
      end
   end

   // =====================================================================
   // snapshot of running time on every START
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         snapStrobe_ff <= 1'b0;
      end else begin
         snapStrobe_ff <= startSeen;
      end
   end

   // =====================================================================
   // transmit shifter, loaded from the current pointer
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         txShift_ff <= '0;
      end else if (sclFall) begin
         if ((state_ff == rtcif_pkg::RTCIF_AACK && readDir_ff) ||
             state_ff == rtcif_pkg::RTCIF_TXACK) begin
            txShift_ff <= rdData;
         end else if (state_ff == rtcif_pkg::RTCIF_TXBYTE && !byteDone) begin
            txShift_ff <= {txShift_ff[6:0], 1'b0};
         end
      end
   end

   // =====================================================================
   // open-drain data driver: only ever pulls low
   always_ff @(posedge core_clk) begin
      sdaOut_ff <= 1'b0;
   end

   always_ff @(posedge core_clk) begin
      if (!nrst || startSeen || stopSeen) begin
         sdaOe_ff <= 1'b0;
      end else if (sclFall) begin
         unique case (state_ff)
            rtcif_pkg::RTCIF_ADDR: begin
               sdaOe_ff <= byteDone && addrMatch;
            end
            rtcif_pkg::RTCIF_RXBYTE: begin
               sdaOe_ff <= byteDone;
            end
            rtcif_pkg::RTCIF_AACK: begin
               sdaOe_ff <= readDir_ff && !rdData[7];
            end
            rtcif_pkg::RTCIF_TXBYTE: begin
               sdaOe_ff <= !byteDone && !txShift_ff[6];
            end
            rtcif_pkg::RTCIF_TXACK: begin
               sdaOe_ff <= !rdData[7];
            end
            rtcif_pkg::RTCIF_IDLE, rtcif_pkg::RTCIF_IGNORE,
            rtcif_pkg::RTCIF_RXACK: begin
               sdaOe_ff <= 1'b0;
            end
            default: begin
               sdaOe_ff <= 1'b0;
            end
         endcase
      end
   end

endmodule

//--- src/rtcif_pin_sync.sv
/*
 * Three-stage synchroniser with agreement filter for pin inputs.
 * Assumes pins are asynchronous to core_clk; idle level is high.
 */
`timescale 1ns/1ps
`include "rtcif_consts.svh"

module rtcif_pin_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             nrst,
   // pins and filtered levels
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] level_ff
);

   logic [WIDTH-1:0] stage1_ff;
   logic [WIDTH-1:0] stage2_ff;
   logic [WIDTH-1:0] stage3_ff;

   if (WIDTH < 1) begin : g_chk
      $error("rtcif_pin_sync: WIDTH must be at least 1");
   end

   // =====================================================================
   // chain; stage1 feeds stage2 only
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         stage1_ff <= {WIDTH{`RTCIF_LINE_IDLE}};
         stage2_ff <= {WIDTH{`RTCIF_LINE_IDLE}};
         stage3_ff <= {WIDTH{`RTCIF_LINE_IDLE}};
      end else begin
         stage1_ff <= pinIn;
         stage2_ff <= stage1_ff;
         stage3_ff <= stage2_ff;
      end
   end

   // =====================================================================
   // a change counts once stages two and three agree
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         level_ff <= {WIDTH{`RTCIF_LINE_IDLE}};
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2_ff[i] == stage3_ff[i]) begin
               level_ff[i] <= stage3_ff[i];
            end
         end
      end
   end

endmodule

//--- src/rtcif_pkg.sv
/*
 * Types of the clock/calendar two-wire slave port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rtcif_pkg;

   // =====================================================================
   // protocol states, gray-coded along the usual path
   typedef enum logic [2:0] {
      RTCIF_IDLE   = 3'h0,
      RTCIF_ADDR   = 3'h1,
      RTCIF_AACK   = 3'h3,
      RTCIF_RXBYTE = 3'h2,
      RTCIF_RXACK  = 3'h6,
      RTCIF_TXBYTE = 3'h7,
      RTCIF_TXACK  = 3'h5,
      RTCIF_IGNORE = 3'h4
   } rtcif_state_e;

endpackage
